// ### shared/acdp_pkg.sv
// Shared constants and types for the accumulator ALU datapath
package acdp_pkg;
  // ----------------------------------------
  // Widths and timing
  // ----------------------------------------
  localparam int DW = 8;
  localparam int PCW = 12;
  localparam int PGW = 4;
  localparam int PDW = 15;
  localparam int ICYCLE_CLKS = 4;
  localparam int STK_DEPTH = 8;
  localparam int SPW = $clog2(STK_DEPTH);
  localparam int MEM_DEPTH = 192;
  localparam int RAW = 2;
  // ----------------------------------------
  // Fixed addresses, offsets and values
  // ----------------------------------------
  localparam logic [DW-1:0] PC_LOW_ADDR = 8'h02;
  localparam logic [RAW-1:0] REG_WREG = 2'h0;
  localparam logic [RAW-1:0] REG_FLAGS = 2'h1;
  localparam logic [RAW-1:0] REG_PC_LOW = 2'h2;
  localparam logic [RAW-1:0] REG_TBLH = 2'h3;
  localparam logic [DW-1:0] WREG_RST = 8'h00;
  localparam logic [PCW-1:0] PC_RST = 12'h000;
  localparam logic [PCW-1:0] PC_STEP = 12'h001;
  localparam logic [PCW-1:0] PC_SKIP = 12'h002;
  localparam logic [PGW-1:0] LAST_PAGE = 4'hF;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [DW:0] BCD_LO_FIX = 9'h006;
  localparam logic [DW:0] BCD_HI_FIX = 9'h060;
  localparam logic [DW-1:0] BYTE_ONE = 8'h01;
  localparam logic [DW-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DW-1:0] BYTE_ONES = 8'hFF;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [5:0] {
    OP_NOP, OP_MOVAM, OP_MOVMA, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_BCD_FIX,
    OP_AND, OP_OR, OP_XOR, OP_INVERT, OP_INC, OP_DEC, OP_RR, OP_RRC, OP_RL,
    OP_RLC, OP_SWAP, OP_CLR, OP_SET, OP_BCLR, OP_BSET, OP_JMP, OP_CALL,
    OP_RET, OP_RETA, OP_RETI, OP_SZ, OP_SZA, OP_SZB, OP_SNZB, OP_SIZ,
    OP_SDZ, OP_TABRDC, OP_TABRDL
  } acdp_op_t;
  typedef enum logic [1:0] {ST_FETCH, ST_EXEC, ST_EXTRA} acdp_state_t;
  typedef struct packed {
    acdp_op_t op;
    logic to_mem;
    logic use_imm;
    logic [DW-1:0] addr;
    logic [DW-1:0] imm;
    logic [2:0] bit_sel;
    logic [PCW-1:0] target;
  } acdp_instr_t;
  typedef struct packed {
    logic rng;
    logic z;
    logic hc;
    logic c;
  } acdp_flags_t;
  localparam acdp_flags_t FLAGS_RST = 4'h0;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [RAW-1:0] addr;
    logic [DW-1:0] wdata;
  } acdp_bus_t;
endpackage

// ### core/acdp_phase.sv
// Instruction-cycle phase counter
`timescale 1ns/1ps
`default_nettype none
module acdp_phase
  import acdp_pkg::*;
#(
  parameter int CLKS = ICYCLE_CLKS
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  output logic [$clog2(CLKS)-1:0] o_phase,
  output logic o_last
);
  localparam int PW = $clog2(CLKS);
  localparam logic [PW-1:0] LAST = PW'(CLKS - 1);
  typedef struct packed {
    logic [PW-1:0] cnt;
  } acdp_ph_st_t;
  acdp_ph_st_t ph_reg;
  acdp_ph_st_t ph_next;

  always_comb begin
    ph_next = ph_reg;
    if (ph_reg.cnt == LAST) begin
      ph_next.cnt = '0;
    end else begin
      ph_next.cnt = ph_reg.cnt + PW'(1);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ph_reg <= '0;
    end else if (i_ce) begin
      ph_reg <= ph_next;
    end
  end

  assign o_phase = ph_reg.cnt;
  assign o_last = (ph_reg.cnt == LAST);
endmodule
`default_nettype wire

// ### core/acdp_core.sv
// Accumulator ALU datapath with instruction-cycle sequencing
// Functional notes
// - Every instruction cycle lasts exactly four system clock periods.
// - Ordinary ops take one cycle; jump, call, returns, table reads take two.
// - Writing the program counter low byte jumps there and costs one extra cycle.
// - A skip test costs one cycle, or two when the skip is taken.
// - Moves: memory to working register, working register to memory, immediate in.
// - Carry set when a sum passes 255; carry clear marks a borrow below 0.
// - Add and subtract forms update zero, carry, half-byte carry and signed range.
// - Memory forms of add write the sum back into the addressed location.
// - Subtract memory or immediate, optionally with borrow; memory forms store there.
// - BCD fixup adjusts the working register, stores to memory, touches only carry.
// - AND, OR, XOR write working register or memory and touch only zero.
// - Zero flag set exactly when a logic result is zero.
// - Invert complements a memory byte into memory or working register, zero only.
// - Increment and decrement by one into memory or working register, zero only.
// - Bit set and clear change only the chosen bit 0 to 7.
// - Rotates move one place; through-carry forms pass the leaving bit to carry.
// - Call saves the next address, return resumes there, jump saves nothing.
// - Conditional tests on a byte or bit proceed or skip the next instruction.
// - Table reads fetch program memory words into data memory.
// - Add-with-carry sums memory, working register and carry into working register.
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module acdp_core
  import acdp_pkg::*;
#(
  parameter int DEPTH = MEM_DEPTH
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_instr_valid,
  input wire acdp_instr_t i_instr,
  output logic o_instr_ready,
  output logic o_done,
  output logic [PCW-1:0] o_pc,
  output logic [DW-1:0] o_working_reg,
  output acdp_flags_t o_flags,
  output logic [PCW-1:0] o_prog_addr,
  input wire logic [PDW-1:0] i_prog_data,
  input wire acdp_bus_t i_bus,
  output logic [DW-1:0] o_rd_data
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    acdp_state_t st;
    acdp_instr_t ins;
    logic [DW-1:0] wreg;
    acdp_flags_t fl;
    logic [PCW-1:0] pc;
    logic [SPW-1:0] sp;
    logic [STK_DEPTH-1:0][PCW-1:0] stk;
    logic [PDW-DW-1:0] tblh;
    logic [PCW-1:0] paddr;
    logic [DW-1:0] rdata;
    logic done;
  } acdp_core_st_t;
  acdp_core_st_t st_reg;
  acdp_core_st_t st_next;
  // Data memory is read combinationally and written on the commit edge, or at the end of the extra cycle for table reads
  logic [DW-1:0] mem [DEPTH];
  logic [1:0] phase;
  logic ph_last;
  acdp_instr_t ins;
  logic [DW-1:0] a;
  logic [DW-1:0] m;
  logic [DW-1:0] b;
  logic [DW-1:0] bx;
  logic [DW-1:0] res;
  logic [DW-1:0] mask;
  logic [DW:0] sum9;
  logic [DW:0] d;
  logic [4:0] lo5;
  logic sub;
  logic cin;
  logic to_mem;
  logic to_wreg;
  logic skip;
  logic xtra;
  logic pc_low_wr;
  logic tab;
  logic commit;
  logic accept;
  logic mem_we;
  logic [DW-1:0] mem_wd;
  acdp_flags_t nfl;

  acdp_phase #(.CLKS(ICYCLE_CLKS)) acdp_phase_inst (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .o_phase(phase),
    .o_last(ph_last)
  );

  // Instructions are taken only at phase 0 so each spans one full cycle
  assign o_instr_ready = (st_reg.st == ST_FETCH) && (phase == '0);
  assign accept = o_instr_ready && i_instr_valid;
  assign commit = (st_reg.st == ST_EXEC) && ph_last;
  // ----------------------------------------
  // ALU
  // ----------------------------------------
  always_comb begin
    ins = st_reg.ins;
    a = st_reg.wreg;
    m = BYTE_ZERO;
    if (ins.addr == PC_LOW_ADDR) begin
      m = st_reg.pc[DW-1:0];
    end else if (ins.addr < DW'(DEPTH)) begin
      m = mem[ins.addr];
    end
    b = ins.use_imm ? ins.imm : m;
    sub = ins.op inside {OP_SUB, OP_SBC};
    // Borrow is the inverted carry, so a subtract adds the complement
    cin = (ins.op inside {OP_ADC, OP_SBC}) ? st_reg.fl.c : sub;
    bx = sub ? ~b : b;
    sum9 = {1'h0, a} + {1'h0, bx} + {8'h00, cin};
    lo5 = {1'h0, a[3:0]} + {1'h0, bx[3:0]} + {4'h0, cin};
    mask = BYTE_ONE << ins.bit_sel;
    d = {1'h0, a};
    res = m;
    nfl = st_reg.fl;
    to_mem = 1'h0;
    to_wreg = 1'h0;
    skip = 1'h0;
    xtra = 1'h0;
    unique case (ins.op)
      OP_NOP: ;
      OP_MOVAM: begin
        res = b;
        to_wreg = 1'h1;
      end
      OP_MOVMA: begin
        res = a;
        to_mem = 1'h1;
      end
      OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
        res = sum9[DW-1:0];
        nfl.c = sum9[DW];
        nfl.hc = lo5[4];
        nfl.rng = (a[DW-1] == bx[DW-1]) && (res[DW-1] != a[DW-1]);
        nfl.z = (res == BYTE_ZERO);
        to_mem = ins.to_mem;
      end
      OP_BCD_FIX: begin
        if ((a[3:0] > BCD_MAX) || st_reg.fl.hc) begin
          d = d + BCD_LO_FIX;
        end
        if ((d[7:4] > BCD_MAX) || st_reg.fl.c || d[DW]) begin
          d = d + BCD_HI_FIX;
        end
        res = d[DW-1:0];
        nfl.c = d[DW] || st_reg.fl.c;
        to_mem = 1'h1;
      end
      OP_AND, OP_OR, OP_XOR: begin
        res = (ins.op == OP_AND) ? (a & b) : (ins.op == OP_OR) ? (a | b) : (a ^ b);
        nfl.z = (res == BYTE_ZERO);
        to_mem = ins.to_mem;
      end
      OP_INVERT, OP_INC, OP_DEC: begin
        res = (ins.op == OP_INVERT) ? ~m : (ins.op == OP_INC) ? m + BYTE_ONE : m - BYTE_ONE;
        nfl.z = (res == BYTE_ZERO);
        to_mem = ins.to_mem;
      end
      OP_RR, OP_RRC: begin
        res = {(ins.op == OP_RRC) ? st_reg.fl.c : m[0], m[DW-1:1]};
        if (ins.op == OP_RRC) begin
          nfl.c = m[0];
        end
        to_mem = ins.to_mem;
      end
      OP_RL, OP_RLC: begin
        res = {m[DW-2:0], (ins.op == OP_RLC) ? st_reg.fl.c : m[DW-1]};
        if (ins.op == OP_RLC) begin
          nfl.c = m[DW-1];
        end
        to_mem = ins.to_mem;
      end
      OP_SWAP: begin
        res = {m[3:0], m[DW-1:4]};
        to_mem = ins.to_mem;
      end
      OP_CLR, OP_SET: begin
        res = (ins.op == OP_SET) ? BYTE_ONES : BYTE_ZERO;
        to_mem = 1'h1;
      end
      OP_BCLR, OP_BSET: begin
        res = (ins.op == OP_BSET) ? (m | mask) : (m & ~mask);
        to_mem = 1'h1;
      end
      OP_JMP, OP_CALL, OP_RET, OP_RETI, OP_TABRDC, OP_TABRDL: begin
        xtra = 1'h1;
      end
      OP_RETA: begin
        res = ins.imm;
        to_wreg = 1'h1;
        xtra = 1'h1;
      end
      OP_SZ, OP_SZA: begin
        skip = (m == BYTE_ZERO);
        to_wreg = (ins.op == OP_SZA);
      end
      OP_SZB, OP_SNZB: begin
        skip = (m[ins.bit_sel] == (ins.op == OP_SNZB));
      end
      OP_SIZ, OP_SDZ: begin
        res = (ins.op == OP_SIZ) ? m + BYTE_ONE : m - BYTE_ONE;
        skip = (res == BYTE_ZERO);
        to_mem = ins.to_mem;
      end
      // Codes outside the enum change no flags but load the addressed byte into the working register
      default: ;
    endcase
    // Result forms that do not go to memory land in the working register
    if (!to_mem && !xtra && !skip && (ins.op != OP_NOP) && (ins.op != OP_MOVMA)) begin
      to_wreg = 1'h1;
    end
    if (ins.op inside {OP_SZA, OP_SIZ, OP_SDZ}) begin
      to_wreg = !to_mem;
    end
    if (ins.op inside {OP_SZ, OP_SZB, OP_SNZB}) begin
      to_wreg = 1'h0;
    end
    pc_low_wr = to_mem && (ins.addr == PC_LOW_ADDR);
    xtra = xtra || skip || pc_low_wr;
    tab = ins.op inside {OP_TABRDC, OP_TABRDL};
  end
  // ----------------------------------------
  // Sequencing and bus
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'h0;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        REG_WREG: st_next.rdata = st_reg.wreg;
        REG_FLAGS: st_next.rdata = DW'(st_reg.fl);
        REG_PC_LOW: st_next.rdata = st_reg.pc[DW-1:0];
        REG_TBLH: st_next.rdata = DW'(st_reg.tblh);
      endcase
    end
    // A software write in the commit cycle is dropped even when the instruction leaves that register alone
    if (i_bus.wr && !commit) begin
      if (i_bus.addr == REG_WREG) begin
        st_next.wreg = i_bus.wdata;
      end else if (i_bus.addr == REG_FLAGS) begin
        st_next.fl = i_bus.wdata[$bits(acdp_flags_t)-1:0];
      end
    end
    unique case (st_reg.st)
      ST_FETCH: begin
        if (accept) begin
          st_next.ins = i_instr;
          st_next.st = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (ph_last) begin
          if (to_wreg) begin
            st_next.wreg = res;
          end
          st_next.fl = nfl;
          st_next.pc = st_reg.pc + (skip ? PC_SKIP : PC_STEP);
          if (pc_low_wr) begin
            st_next.pc[DW-1:0] = res;
          end
          if (ins.op == OP_JMP) begin
            st_next.pc = ins.target;
          end else if (ins.op == OP_CALL) begin
            st_next.stk[st_reg.sp] = st_reg.pc + PC_STEP;
            st_next.sp = st_reg.sp + SPW'(1);
            st_next.pc = ins.target;
          end else if (ins.op inside {OP_RET, OP_RETA, OP_RETI}) begin
            st_next.sp = st_reg.sp - SPW'(1);
            st_next.pc = st_reg.stk[st_reg.sp - SPW'(1)];
          end
          if (tab) begin
            st_next.paddr = {(ins.op == OP_TABRDL) ? LAST_PAGE : st_reg.pc[PCW-1:DW], a};
          end
          st_next.st = xtra ? ST_EXTRA : ST_FETCH;
          st_next.done = !xtra;
        end
      end
      ST_EXTRA: begin
        if (ph_last) begin
          if (tab) begin
            st_next.tblh = i_prog_data[PDW-1:DW];
          end
          st_next.st = ST_FETCH;
          st_next.done = 1'h1;
        end
      end
      default: st_next.st = ST_FETCH;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= '0;
      st_reg.st <= ST_FETCH;
      st_reg.wreg <= WREG_RST;
      st_reg.fl <= FLAGS_RST;
      st_reg.pc <= PC_RST;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  // Table data lands in memory at the end of the second cycle
  assign mem_we = (commit && to_mem && !pc_low_wr) || ((st_reg.st == ST_EXTRA) && ph_last && tab);
  assign mem_wd = commit ? res : i_prog_data[DW-1:0];

  always_ff @(posedge i_core_clk) begin
    if (i_ce && mem_we && (ins.addr < DW'(DEPTH))) begin
      mem[ins.addr] <= mem_wd;
    end
  end

  assign o_done = st_reg.done;
  assign o_pc = st_reg.pc;
  assign o_working_reg = st_reg.wreg;
  assign o_flags = st_reg.fl;
  assign o_prog_addr = st_reg.paddr;
  assign o_rd_data = st_reg.rdata;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn || !i_ce);

  sequence s_one_cycle;
    ##4 o_done;
  endsequence
  sequence s_two_cycle;
    ##4 !o_done ##4 o_done;
  endsequence

  property p_icycle;
    ph_last |=> !ph_last [*3] ##1 ph_last;
  endproperty
  a_icycle: assert property (p_icycle) else $error("cycle not four clocks");

  property p_single;
    accept && (i_instr.op == OP_ADD) && !i_instr.to_mem |-> s_one_cycle;
  endproperty
  a_single: assert property (p_single) else $error("add not one cycle");

  property p_jump_two;
    accept && (i_instr.op == OP_JMP) |-> s_two_cycle;
  endproperty
  a_jump_two: assert property (p_jump_two) else $error("jump not two cycles");

  property p_pc_low_write;
    commit && (ins.op == OP_MOVMA) && (ins.addr == PC_LOW_ADDR) |=> (o_pc[DW-1:0] == $past(a)) ##0 !o_done ##4 o_done;
  endproperty
  a_pc_low_write: assert property (p_pc_low_write) else $error("pc low write not a jump");

  property p_skip;
    commit && skip && !pc_low_wr |=> (o_pc == $past(o_pc) + PC_SKIP) ##0 !o_done ##4 o_done;
  endproperty
  a_skip: assert property (p_skip) else $error("skip timing wrong");

  property p_add_carry;
    commit && (ins.op == OP_ADD) && ins.use_imm |=>
      o_flags.c == (({1'h0, $past(a)} + {1'h0, $past(ins.imm)}) > {1'h0, BYTE_ONES});
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

  property p_logic_zero;
    commit && (ins.op inside {OP_AND, OP_OR, OP_XOR}) && !ins.to_mem |=>
      o_flags.z == (o_working_reg == BYTE_ZERO);
  endproperty
  a_logic_zero: assert property (p_logic_zero) else $error("logic zero wrong");

  property p_bcd_flags;
    commit && (ins.op == OP_BCD_FIX) |=> ({o_flags.rng, o_flags.z, o_flags.hc} == $past({o_flags.rng, o_flags.z, o_flags.hc}));
  endproperty
  a_bcd_flags: assert property (p_bcd_flags) else $error("bcd fixup touched flags");

  property p_bit_only;
    commit && (ins.op == OP_BSET) && !pc_low_wr |-> mem_we && ((mem_wd ^ m) == (mask & ~m));
  endproperty
  a_bit_only: assert property (p_bit_only) else $error("bit set changed others");

  property p_call_save;
    commit && (ins.op == OP_CALL) |=> (st_reg.stk[$past(st_reg.sp)] == $past(o_pc) + PC_STEP) && (o_pc == $past(ins.target));
  endproperty
  a_call_save: assert property (p_call_save) else $error("call address not saved");
endmodule
`default_nettype wire

// ### bench/test_accumulator_alu_datapath.sv
// Self-checking testbench for the accumulator ALU datapath core
`timescale 1ns/1ps
`default_nettype none
module test_accumulator_alu_datapath import acdp_pkg::*; ;
  // ----------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_ce = 1'b1;
  logic i_instr_valid = 1'b0;
  acdp_instr_t i_instr = '0;
  acdp_bus_t i_bus = '0;
  logic [PDW-1:0] i_prog_data = 15'h5A3C;
  logic o_instr_ready;
  logic o_done;
  logic [PCW-1:0] o_pc;
  logic [PCW-1:0] o_prog_addr;
  logic [DW-1:0] o_working_reg;
  logic [DW-1:0] o_rd_data;
  acdp_flags_t o_flags;
  logic [DW-1:0] rv;
  int fail_count = 0;
  int samples_checked = 0;

  always #4 i_core_clk = ~i_core_clk;

  acdp_core acdp_core_inst (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_instr_valid(i_instr_valid),
    .i_instr(i_instr),
    .o_instr_ready(o_instr_ready),
    .o_done(o_done),
    .o_pc(o_pc),
    .o_working_reg(o_working_reg),
    .o_flags(o_flags),
    .o_prog_addr(o_prog_addr),
    .i_prog_data(i_prog_data),
    .i_bus(i_bus),
    .o_rd_data(o_rd_data)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, s);
      fail_count++;
    end
  endtask

  // Offers one instruction and checks the clocks from accept to done
  task automatic ex(input acdp_op_t op, input logic tm, input logic ui, input logic [7:0] a,
                    input logic [7:0] x, input logic [11:0] tg, input int n);
    int j;
    int k;
    j = 0;
    k = 0;
    @(posedge i_core_clk);
    i_instr_valid <= 1'b1;
    i_instr <= '{op: op, to_mem: tm, use_imm: ui, addr: a, imm: x, bit_sel: x[2:0], target: tg};
    @(negedge i_core_clk);
    while (o_instr_ready !== 1'b1 && j < 20) begin
      @(negedge i_core_clk);
      j++;
    end
    @(posedge i_core_clk);
    i_instr_valid <= 1'b0;
    do begin
      @(posedge i_core_clk);
      #1;
      k++;
    end while (o_done !== 1'b1 && k < 20);
    // Done shows just after the last edge of the instruction; k does not count the accept edge, so add one
    chk("cycles", 16'(n), 16'(k + 1));
  endtask

  task automatic li(input logic [7:0] x);
    ex(OP_MOVAM, 1'b0, 1'b1, 8'h00, x, 12'h000, 4);
  endtask
  task automatic st(input logic [7:0] a);
    ex(OP_MOVMA, 1'b1, 1'b0, a, 8'h00, 12'h000, 4);
  endtask
  task automatic ld(input logic [7:0] a);
    ex(OP_MOVAM, 1'b0, 1'b0, a, 8'h00, 12'h000, 4);
  endtask

  // Bus writes only between instructions: a write in a commit cycle is dropped
  task automatic wr(input logic [RAW-1:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_core_clk);
    i_bus <= '0;
  endtask
  task automatic rd(input logic [RAW-1:0] a);
    @(posedge i_core_clk);
    i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_core_clk);
    i_bus <= '0;
    #1 rv = o_rd_data;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_move();
    li(8'h5A);
    chk("wreg", 8'h5A, o_working_reg);
    st(8'h40);
    li(8'h00);
    ld(8'h40);
    chk("wreg", 8'h5A, o_working_reg);
  endtask

  task automatic t_add();
    li(8'hF0);
    ex(OP_ADD, 1'b0, 1'b1, 8'h00, 8'h20, 12'h000, 4);
    chk("wreg", 8'h10, o_working_reg);
    chk("flags", 4'h1, o_flags);
    li(8'h80);
    ex(OP_ADD, 1'b0, 1'b1, 8'h00, 8'h80, 12'h000, 4);
    chk("flags", 4'hD, o_flags);
    li(8'h0F);
    ex(OP_ADD, 1'b0, 1'b1, 8'h00, 8'h01, 12'h000, 4);
    chk("flags", 4'h2, o_flags);
    wr(REG_FLAGS, 8'h01);
    ex(OP_ADC, 1'b0, 1'b0, 8'h40, 8'h00, 12'h000, 4);
    chk("wreg", 8'h6B, o_working_reg);
    chk("flags", 4'h0, o_flags);
    ex(OP_ADD, 1'b1, 1'b0, 8'h40, 8'h00, 12'h000, 4);
    chk("wreg", 8'h6B, o_working_reg);
    chk("flags", 4'hA, o_flags);
    ld(8'h40);
    chk("mem", 8'hC5, o_working_reg);
  endtask

  task automatic t_sub();
    li(8'h10);
    ex(OP_SUB, 1'b0, 1'b1, 8'h00, 8'h20, 12'h000, 4);
    chk("wreg", 8'hF0, o_working_reg);
    chk("carry", 1'b0, o_flags.c);
    ex(OP_SUB, 1'b0, 1'b1, 8'h00, 8'hF0, 12'h000, 4);
    chk("zero", 1'b1, o_flags.z);
    chk("carry", 1'b1, o_flags.c);
    li(8'h10);
    st(8'h41);
    li(8'h30);
    wr(REG_FLAGS, 8'h00);
    ex(OP_SBC, 1'b1, 1'b0, 8'h41, 8'h00, 12'h000, 4);
    chk("wreg", 8'h30, o_working_reg);
    chk("carry", 1'b1, o_flags.c);
    ld(8'h41);
    chk("mem", 8'h1F, o_working_reg);
  endtask

  task automatic t_logic();
    acdp_op_t ops [3];
    logic [7:0] res [3];
    ops = '{OP_AND, OP_OR, OP_XOR};
    res = '{8'h00, 8'hFF, 8'h00};
    for (int i = 0; i < 3; i++) begin
      wr(REG_FLAGS, 8'h0B);
      li(8'hF0);
      ex(ops[i], 1'b0, 1'b1, 8'h00, (i == 2) ? 8'hF0 : 8'h0F, 12'h000, 4);
      chk("logic", res[i], o_working_reg);
      chk("flags", {1'b1, res[i] == 8'h00, 2'b11}, o_flags);
    end
    li(8'h0F);
    ex(OP_XOR, 1'b1, 1'b0, 8'h40, 8'h00, 12'h000, 4);
    chk("wreg", 8'h0F, o_working_reg);
    ld(8'h40);
    chk("mem", 8'hCA, o_working_reg);
  endtask

  task automatic t_unary();
    li(8'h00);
    st(8'h42);
    ex(OP_INVERT, 1'b1, 1'b0, 8'h42, 8'h00, 12'h000, 4);
    chk("zero", 1'b0, o_flags.z);
    ex(OP_INC, 1'b1, 1'b0, 8'h42, 8'h00, 12'h000, 4);
    chk("zero", 1'b1, o_flags.z);
    ex(OP_DEC, 1'b0, 1'b0, 8'h42, 8'h00, 12'h000, 4);
    chk("wreg", 8'hFF, o_working_reg);
    chk("zero", 1'b0, o_flags.z);
    ld(8'h42);
    chk("mem", 8'h00, o_working_reg);
    ex(OP_BSET, 1'b1, 1'b0, 8'h42, 8'h03, 12'h000, 4);
    ld(8'h42);
    chk("mem", 8'h08, o_working_reg);
    li(8'hFF);
    st(8'h42);
    ex(OP_BCLR, 1'b1, 1'b0, 8'h42, 8'h07, 12'h000, 4);
    ld(8'h42);
    chk("mem", 8'h7F, o_working_reg);
    wr(REG_FLAGS, 8'h00);
    ex(OP_RRC, 1'b0, 1'b0, 8'h42, 8'h00, 12'h000, 4);
    chk("wreg", 8'h3F, o_working_reg);
    chk("carry", 1'b1, o_flags.c);
  endtask

  task automatic t_daa();
    li(8'h19);
    ex(OP_ADD, 1'b0, 1'b1, 8'h00, 8'h28, 12'h000, 4);
    ex(OP_BCD_FIX, 1'b1, 1'b0, 8'h43, 8'h00, 12'h000, 4);
    chk("wreg", 8'h41, o_working_reg);
    chk("flags", 4'h2, o_flags);
    ld(8'h43);
    chk("mem", 8'h47, o_working_reg);
  endtask

  // Program counter values are tracked by hand from the jump target onward
  task automatic t_branch();
    ex(OP_JMP, 1'b0, 1'b0, 8'h00, 8'h00, 12'h123, 8);
    chk("pc", 12'h123, o_pc);
    ex(OP_CALL, 1'b0, 1'b0, 8'h00, 8'h00, 12'h300, 8);
    chk("pc", 12'h300, o_pc);
    ex(OP_RET, 1'b0, 1'b0, 8'h00, 8'h00, 12'h000, 8);
    chk("pc", 12'h124, o_pc);
    ex(OP_SZ, 1'b0, 1'b0, 8'h42, 8'h00, 12'h000, 4);
    chk("pc", 12'h125, o_pc);
    li(8'h00);
    st(8'h44);
    ex(OP_SZ, 1'b0, 1'b0, 8'h44, 8'h00, 12'h000, 8);
    chk("pc", 12'h129, o_pc);
    li(8'h55);
    ex(OP_MOVMA, 1'b1, 1'b0, PC_LOW_ADDR, 8'h00, 12'h000, 8);
    chk("pc", 12'h155, o_pc);
    ex(OP_SZB, 1'b0, 1'b0, 8'h42, 8'h07, 12'h000, 8);
    chk("pc", 12'h157, o_pc);
  endtask

  task automatic t_table();
    li(8'h34);
    ex(OP_TABRDL, 1'b1, 1'b0, 8'h45, 8'h00, 12'h000, 8);
    chk("prog_addr", 12'hF34, o_prog_addr);
    rd(REG_TBLH);
    chk("tblh", 8'h5A, rv);
    ld(8'h45);
    chk("mem", 8'h3C, o_working_reg);
  endtask

  task automatic t_bus();
    wr(REG_WREG, 8'hA5);
    rd(REG_WREG);
    chk("wreg", 8'hA5, o_working_reg);
    chk("rd_wreg", 8'hA5, rv);
    // A write while the clock enable is low must not land
    @(posedge i_core_clk);
    i_ce <= 1'b0;
    wr(REG_WREG, 8'h3C);
    i_ce <= 1'b1;
    rd(REG_WREG);
    chk("ce_hold", 8'hA5, rv);
    wr(REG_FLAGS, 8'h09);
    rd(REG_FLAGS);
    chk("rd_flags", 8'h09, rv);
    wr(REG_PC_LOW, 8'h00);
    rd(REG_PC_LOW);
    chk("rd_pc_low", 8'h5A, rv);
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic wrap_up();
    $display("Checks made: %0d, mismatches: %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    t_move();
    t_add();
    t_sub();
    t_logic();
    t_unary();
    t_daa();
    t_branch();
    t_table();
    t_bus();
    wrap_up();
  end

  // Roughly 60 instructions of at most 12 clocks each; well over ten times that margin
  initial begin
    #100000;
    fail_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
